// *** brt_engine.sv ***
`timescale 1ns/1ps

// Behaviour
// - Control scan holds register during Capture-DR.
// - Operation decoded from control bits two to zero.
// - Operation runs only under run-test in Idle.
// - X00 toggle, X01 pattern16, X10 signature16.
// - 011 signature+pattern, 111 signature+count.
// - Control cells never join any algorithm.
// - Output-enable cells still steer pin drive.
// - Operations need exactly one direction, else cells hold.
// - Bits ten to three mask inputs seven to zero.
// - Mask one ignores pin, zero compresses it.
// - Toggle mode samples inputs, shadows feed core.
// - Toggle inverts outputs, drives pins on falling edge.
// - Pattern16 LFSR advances, drives outputs, feeds core.
// - All-zero pattern seed stays zero.
// - Signature16 compresses inputs, shadows feed core.
// - Signature16 keeps output shadows and pins unchanged.
// - Combined modes compress inputs into 8-bit signature.
// - Signature+pattern runs 8-bit output LFSR.
// - Signature+count increments 8-bit output counter.
// - Opposite outputs count carries, sixteen bits overall.
// - Run-test selects bypass register, test mode.
module brt_engine #(
    parameter logic [15:0] TAPS16_AB = 16'hD008,
    parameter logic [15:0] TAPS16_BA = 16'hD008,
    parameter logic [7:0]  TAPS8_AB  = 8'hB8,
    parameter logic [7:0]  TAPS8_BA  = 8'hB8
) (
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       tck,
    input  wire logic       tdi,
    input  wire logic       tap_run_idle,
    input  wire logic       tap_capture_dr,
    input  wire logic       tap_shift_dr,
    input  wire logic       tap_update_dr,
    input  wire logic       control_scan_normal,
    input  wire logic       control_scan_test,
    input  wire logic       run_boundary_test_op,
    input  wire logic       chain_select,
    input  wire logic [7:0] a_pins_in,
    input  wire logic [7:0] b_pins_in,
    output logic      [7:0] a_pins_out,
    output logic      [7:0] b_pins_out,
    output logic            a_pins_oe,
    output logic            b_pins_oe,
    output logic      [7:0] core_a_in,
    output logic      [7:0] core_b_in,
    output logic            tdo,
    output logic            tdo_oe,
    output logic            test_mode,
    output logic     [10:0] run_test_control,
    output logic            sys_run_active,
    output logic            sys_a_to_b
);

    // ------------------------------------------------------------------
    // Link-side state, rising edge of the test clock
    // ------------------------------------------------------------------
    brt_pkg::brt_tck_s  t;
    brt_pkg::brt_tck_s  next_t;
    brt_pkg::brt_fall_s f;
    brt_pkg::brt_fall_s next_f;
    brt_pkg::brt_sys_s  s;
    brt_pkg::brt_sys_s  next_s;

    brt_pkg::brt_op_e   op;
    logic               a_to_b;
    logic               one_dir;
    logic               run_active;
    logic               ctl_sel;
    logic [7:0]         pins_sel;
    logic [7:0]         masked;
    logic [5:0]         in_lsb;
    logic [5:0]         out_lsb;
    logic [5:0]         opp_lsb;
    logic [7:0]         in_sr;
    logic [7:0]         out_sr;
    logic [7:0]         opp_sr;
    logic [7:0]         new_in;
    logic [7:0]         new_out;
    logic [7:0]         new_opp;
    logic [15:0]        word16;
    logic [15:0]        taps16;
    logic [7:0]         taps8;
    logic               upd_out;

    always_comb begin
        next_t  = t;
        ctl_sel = control_scan_normal | control_scan_test;
        // Output-enable cells are active low; A floating means A-to-B.
        a_to_b  = t.sh[brt_pkg::OE_A_BIT] & ~t.sh[brt_pkg::OE_B_BIT];
        one_dir = t.sh[brt_pkg::OE_A_BIT] ^ t.sh[brt_pkg::OE_B_BIT];
        op      = brt_pkg::brt_decode(
                      t.run_test_control[brt_pkg::OPCODE_MSB:
                                         brt_pkg::OPCODE_LSB]);
        run_active = run_boundary_test_op & tap_run_idle & one_dir;

        // Pins are asynchronous to the test clock, so two stages first.
        next_t.a_sync1 = a_pins_in;
        next_t.a_sync2 = t.a_sync1;
        next_t.b_sync1 = b_pins_in;
        next_t.b_sync2 = t.b_sync1;

        in_lsb   = a_to_b ? brt_pkg::A_IN_LSB  : brt_pkg::B_IN_LSB;
        out_lsb  = a_to_b ? brt_pkg::B_OUT_LSB : brt_pkg::A_OUT_LSB;
        opp_lsb  = a_to_b ? brt_pkg::A_OUT_LSB : brt_pkg::B_OUT_LSB;
        taps16   = a_to_b ? TAPS16_AB : TAPS16_BA;
        taps8    = a_to_b ? TAPS8_AB  : TAPS8_BA;
        pins_sel = a_to_b ? t.a_sync2 : t.b_sync2;
        masked   = pins_sel & ~t.run_test_control[brt_pkg::MASK_MSB:
                                                  brt_pkg::MASK_LSB];
        in_sr    = t.sr[in_lsb +: brt_pkg::LANE_WIDTH];
        out_sr   = t.sr[out_lsb +: brt_pkg::LANE_WIDTH];
        opp_sr   = t.sr[opp_lsb +: brt_pkg::LANE_WIDTH];
        new_in   = in_sr;
        new_out  = out_sr;
        new_opp  = opp_sr;
        upd_out  = 1'b1;
        word16   = {out_sr, in_sr};

        case (op)
            brt_pkg::OP_SAMPLE_TOGGLE: begin
                new_in  = pins_sel;
                new_out = ~out_sr;
            end
            brt_pkg::OP_PATTERN16: begin
                // A zero seed feeds back zero and so stays put.
                word16  = brt_pkg::brt_lfsr16(word16, taps16);
                new_in  = word16[7:0];
                new_out = word16[15:8];
            end
            brt_pkg::OP_SIGNATURE16: begin
                word16  = brt_pkg::brt_lfsr16(word16, taps16)
                          ^ {8'h00, masked};
                new_in  = word16[7:0];
                new_out = word16[15:8];
                upd_out = 1'b0;
            end
            brt_pkg::OP_SIG_PATTERN: begin
                new_in  = brt_pkg::brt_lfsr8(in_sr, taps8) ^ masked;
                new_out = brt_pkg::brt_lfsr8(out_sr, taps8);
            end
            brt_pkg::OP_SIG_COUNT: begin
                new_in  = brt_pkg::brt_lfsr8(in_sr, taps8) ^ masked;
                new_out = out_sr + 8'h01;
                if (out_sr == 8'hFF) begin
                    new_opp = opp_sr + 8'h01;
                end
            end
            default: begin
                new_in = in_sr;
            end
        endcase

        if (run_active) begin
            // Only data lanes are written; control cells sit untouched.
            next_t.sr[in_lsb +: brt_pkg::LANE_WIDTH]  = new_in;
            next_t.sr[out_lsb +: brt_pkg::LANE_WIDTH] = new_out;
            next_t.sr[opp_lsb +: brt_pkg::LANE_WIDTH] = new_opp;
            next_t.sh[in_lsb +: brt_pkg::LANE_WIDTH]  = new_in;
            if (upd_out) begin
                next_t.sh[out_lsb +: brt_pkg::LANE_WIDTH] = new_out;
            end
        end else if (chain_select && tap_shift_dr) begin
            // Seeding path: the chain is shifted toward bit zero.
            next_t.sr = {tdi, t.sr[brt_pkg::CHAIN_LEN-1:1]};
        end else if (chain_select && tap_update_dr) begin
            next_t.sh = t.sr;
        end

        // Capture leaves the shift stage alone, so software reads back
        // exactly what it loaded.
        if (ctl_sel && tap_shift_dr) begin
            next_t.rtc_shift = {tdi, t.rtc_shift[brt_pkg::RTC_WIDTH-1:1]};
        end else if (ctl_sel && tap_update_dr) begin
            next_t.run_test_control = t.rtc_shift;
        end

        if (!ctl_sel && !chain_select) begin
            if (tap_capture_dr) begin
                next_t.bypass = 1'b0;
            end else if (tap_shift_dr) begin
                next_t.bypass = tdi;
            end
        end

        next_t.run_flag = run_active;
        next_t.dir_flag = a_to_b;
    end

    always_ff @(posedge tck or negedge rstn) begin
        if (!rstn) begin
            t <= '0;
        end else begin
            t <= next_t;
        end
    end

    // ------------------------------------------------------------------
    // Falling edge: pins and serial output
    // ------------------------------------------------------------------
    always_comb begin
        next_f            = f;
        next_f.a_pins_out = t.sh[brt_pkg::A_OUT_LSB +: brt_pkg::LANE_WIDTH];
        next_f.b_pins_out = t.sh[brt_pkg::B_OUT_LSB +: brt_pkg::LANE_WIDTH];
        next_f.a_pins_oe  = ~t.sh[brt_pkg::OE_A_BIT];
        next_f.b_pins_oe  = ~t.sh[brt_pkg::OE_B_BIT];
        next_f.tdo_oe     = tap_shift_dr;
        next_f.test_mode  = run_boundary_test_op | control_scan_test;
        if (control_scan_normal || control_scan_test) begin
            next_f.tdo = t.rtc_shift[0];
        end else if (chain_select) begin
            next_f.tdo = t.sr[0];
        end else begin
            next_f.tdo = t.bypass;
        end
    end

    always_ff @(negedge tck or negedge rstn) begin
        if (!rstn) begin
            f <= '0;
        end else begin
            f <= next_f;
        end
    end

    // ------------------------------------------------------------------
    // System-clock status crossing
    // ------------------------------------------------------------------
    always_comb begin
        next_s        = s;
        next_s.run_s1 = t.run_flag;
        next_s.run_s2 = s.run_s1;
        next_s.dir_s1 = t.dir_flag;
        next_s.dir_s2 = s.dir_s1;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign a_pins_out       = f.a_pins_out;
    assign b_pins_out       = f.b_pins_out;
    assign a_pins_oe        = f.a_pins_oe;
    assign b_pins_oe        = f.b_pins_oe;
    assign tdo              = f.tdo;
    assign tdo_oe           = f.tdo_oe;
    assign test_mode        = f.test_mode;
    assign core_a_in        = t.sh[brt_pkg::A_IN_LSB +: brt_pkg::LANE_WIDTH];
    assign core_b_in        = t.sh[brt_pkg::B_IN_LSB +: brt_pkg::LANE_WIDTH];
    assign run_test_control = t.run_test_control;
    assign sys_run_active   = s.run_s2;
    assign sys_a_to_b       = s.dir_s2;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_ctl_capture_hold: assert property (
        @(posedge tck) disable iff (!rstn)
        (control_scan_test || control_scan_normal) && tap_capture_dr
        && !tap_shift_dr |=> $stable(t.rtc_shift))
        else $error("Control shift stage changed on capture.");

    a_idle_no_run: assert property (
        @(posedge tck) disable iff (!rstn)
        !run_active && !chain_select |=> $stable(t.sr))
        else $error("Boundary cells moved outside a run.");

    a_ctl_excluded: assert property (
        @(posedge tck) disable iff (!rstn)
        run_active |=> $stable(t.sr[brt_pkg::CTL_MSB:brt_pkg::CTL_LSB]))
        else $error("Control cells joined an operation.");

    a_toggle_invert: assert property (
        @(posedge tck) disable iff (!rstn)
        run_active && op == brt_pkg::OP_SAMPLE_TOGGLE && a_to_b
        |=> t.sr[15:8] == ~$past(t.sr[15:8]) && t.sh[15:8] == t.sr[15:8])
        else $error("Toggle did not invert selected outputs.");

    a_zero_seed: assert property (
        @(posedge tck) disable iff (!rstn)
        run_active && op == brt_pkg::OP_PATTERN16 && a_to_b
        && t.sr[15:0] == 16'h0000 |=> t.sr[15:0] == 16'h0000)
        else $error("Zero seed produced a pattern.");

    a_sig_out_hold: assert property (
        @(posedge tck) disable iff (!rstn)
        run_active && op == brt_pkg::OP_SIGNATURE16 && !a_to_b
        |=> $stable(t.sh[31:24]) ##1 a_pins_out == $past(t.sh[31:24], 2))
        else $error("Output shadows changed during signature.");

    a_count_up: assert property (
        @(posedge tck) disable iff (!rstn)
        run_active && op == brt_pkg::OP_SIG_COUNT && a_to_b
        |=> t.sr[15:8] == $past(t.sr[15:8]) + 8'h01)
        else $error("Counter did not increment.");

    a_carry_count: assert property (
        @(posedge tck) disable iff (!rstn)
        run_active && op == brt_pkg::OP_SIG_COUNT && !a_to_b
        && t.sr[31:24] == 8'hFF
        |=> t.sr[15:8] == $past(t.sr[15:8]) + 8'h01)
        else $error("Carry not counted by opposite cells.");

    a_mask_ignore: assert property (
        @(posedge tck) disable iff (!rstn)
        run_active && op == brt_pkg::OP_SIG_PATTERN && a_to_b
        && t.run_test_control[10:3] == 8'hFF
        |=> t.sr[7:0] == brt_pkg::brt_lfsr8($past(t.sr[7:0]), TAPS8_AB))
        else $error("Masked pins reached the signature.");

    a_oe_follow: assert property (
        @(posedge tck) disable iff (!rstn)
        $stable(t.sh[39:38]) |=> a_pins_oe == !t.sh[39]
        && b_pins_oe == !t.sh[38])
        else $error("Pin enable ignores output-enable cells.");

    a_bypass_capture: assert property (
        @(posedge tck) disable iff (!rstn)
        run_boundary_test_op && !chain_select && !control_scan_normal
        && !control_scan_test && tap_capture_dr && !tap_shift_dr
        |=> t.bypass == 1'b0)
        else $error("Bypass did not capture zero.");

endmodule : brt_engine

// *** brt_pkg.sv ***
package brt_pkg;

    // ------------------------------------------------------------------
    // Run-test control register layout
    // ------------------------------------------------------------------
    localparam int          RTC_WIDTH  = 11;
    localparam int          OPCODE_LSB = 0;
    localparam int          OPCODE_MSB = 2;
    localparam int          MASK_LSB   = 3;
    localparam int          MASK_MSB   = 10;
    localparam logic [10:0] RTC_RESET  = 11'h000;

    // ------------------------------------------------------------------
    // Boundary cell chain layout
    // ------------------------------------------------------------------
    localparam int          CHAIN_LEN  = 40;
    localparam int          LANE_WIDTH = 8;
    localparam logic [5:0]  A_IN_LSB   = 6'h00;
    localparam logic [5:0]  B_OUT_LSB  = 6'h08;
    localparam logic [5:0]  B_IN_LSB   = 6'h10;
    localparam logic [5:0]  A_OUT_LSB  = 6'h18;
    localparam int          CTL_LSB    = 32;
    localparam int          CTL_MSB    = 39;
    localparam int          OE_A_BIT   = 39;
    localparam int          OE_B_BIT   = 38;
    localparam logic [39:0] CHAIN_RESET = 40'h00_0000_0000;

    // ------------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------------
    localparam logic [1:0] OPC_SAMPLE_TOGGLE = 2'h0;
    localparam logic [1:0] OPC_PATTERN16     = 2'h1;
    localparam logic [1:0] OPC_SIGNATURE16   = 2'h2;
    localparam logic [2:0] OPC_SIG_PATTERN   = 3'h3;
    localparam logic [2:0] OPC_SIG_COUNT     = 3'h7;

    typedef enum {
        OP_SAMPLE_TOGGLE,
        OP_PATTERN16,
        OP_SIGNATURE16,
        OP_SIG_PATTERN,
        OP_SIG_COUNT
    } brt_op_e;

    // ------------------------------------------------------------------
    // State carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [10:0] rtc_shift;
        logic [10:0] run_test_control;
        logic        bypass;
        logic [39:0] sr;
        logic [39:0] sh;
        logic [7:0]  a_sync1;
        logic [7:0]  a_sync2;
        logic [7:0]  b_sync1;
        logic [7:0]  b_sync2;
        logic        run_flag;
        logic        dir_flag;
    } brt_tck_s;

    typedef struct packed {
        logic [7:0] a_pins_out;
        logic [7:0] b_pins_out;
        logic       a_pins_oe;
        logic       b_pins_oe;
        logic       tdo;
        logic       tdo_oe;
        logic       test_mode;
    } brt_fall_s;

    typedef struct packed {
        logic run_s1;
        logic run_s2;
        logic dir_s1;
        logic dir_s2;
    } brt_sys_s;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic brt_op_e brt_decode(input logic [2:0] opc);
        brt_op_e op;
        op = OP_SAMPLE_TOGGLE;
        if (opc == OPC_SIG_COUNT) begin
            op = OP_SIG_COUNT;
        end else if (opc == OPC_SIG_PATTERN) begin
            op = OP_SIG_PATTERN;
        end else if (opc[1:0] == OPC_SIGNATURE16) begin
            op = OP_SIGNATURE16;
        end else if (opc[1:0] == OPC_PATTERN16) begin
            op = OP_PATTERN16;
        end
        return op;
    endfunction : brt_decode

    function automatic logic [15:0] brt_lfsr16(input logic [15:0] s,
                                               input logic [15:0] taps);
        return {s[14:0], ^(s & taps)};
    endfunction : brt_lfsr16

    function automatic logic [7:0] brt_lfsr8(input logic [7:0] s,
                                             input logic [7:0] taps);
        return {s[6:0], ^(s & taps)};
    endfunction : brt_lfsr8

endpackage : brt_pkg

// *** brt_tap_model.sv ***
`timescale 1ns/1ps

module brt_tap_model (
    output logic      tck,
    output logic      tdi,
    output logic      tap_run_idle,
    output logic      tap_capture_dr,
    output logic      tap_shift_dr,
    output logic      tap_update_dr,
    output logic      control_scan_test,
    output logic      control_scan_normal,
    output logic      run_boundary_test_op,
    output logic      chain_select,
    input  wire logic tdo
);
    // Picks the normal-mode flavour of the control-register scan.
    logic use_normal;

    // ----------------------------------------------------------------
    // Test controller
    // ----------------------------------------------------------------
    // The test clock rests low between frames, and every level changes
    // mid-way through the low phase so no edge ever races it.
    initial begin
        tck = 1'b0;
        tdi = 1'b0;
        tap_run_idle = 1'b0;
        tap_capture_dr = 1'b0;
        tap_shift_dr = 1'b0;
        tap_update_dr = 1'b0;
        control_scan_test = 1'b0;
        control_scan_normal = 1'b0;
        use_normal = 1'b0;
        run_boundary_test_op = 1'b0;
        chain_select = 1'b0;
    end

    task automatic pulse();
        #20 tck = 1'b1;
        #40 tck = 1'b0;
        #20;
    endtask : pulse

    // Scan n bits in LSB first and collect what leaves on tdo.
    task automatic scan(input logic ctl, input int n,
                        input logic [39:0] din, output logic [39:0] dout);
        dout = 40'h0;
        run_boundary_test_op = 1'b0;
        tap_run_idle = 1'b0;
        control_scan_test = ctl & ~use_normal;
        control_scan_normal = ctl & use_normal;
        chain_select = ~ctl;
        tap_capture_dr = ctl;
        pulse();
        tap_capture_dr = 1'b0;
        tap_shift_dr = 1'b1;
        for (int i = 0; i < n; i++) begin
            tdi = din[i];
            #19 dout[i] = tdo;
            #1 tck = 1'b1;
            #40 tck = 1'b0;
            #20;
        end
        tap_shift_dr = 1'b0;
        tdi = ~tdi;
        tap_update_dr = 1'b1;
        pulse();
        tap_update_dr = 1'b0;
    endtask : scan

    task automatic run(input int n, input logic idle);
        control_scan_test = 1'b0;
        control_scan_normal = 1'b0;
        chain_select = 1'b0;
        run_boundary_test_op = 1'b1;
        tap_run_idle = idle;
        repeat (n) pulse();
    endtask : run

    // Capture and shift two bits through the bypass stage under run-test.
    task automatic bypass_scan(input logic b, output logic [1:0] o);
        control_scan_test = 1'b0;
        control_scan_normal = 1'b0;
        chain_select = 1'b0;
        run_boundary_test_op = 1'b1;
        tap_run_idle = 1'b0;
        tap_capture_dr = 1'b1;
        pulse();
        tap_capture_dr = 1'b0;
        tap_shift_dr = 1'b1;
        tdi = b;
        for (int i = 0; i < 2; i++) begin
            #19 o[i] = tdo;
            #1 tck = 1'b1;
            #40 tck = 1'b0;
            #20;
        end
        tap_shift_dr = 1'b0;
    endtask : bypass_scan
endmodule : brt_tap_model

// *** boundary_run_test_engine_tb_top.sv ***
`timescale 1ns/1ps

module boundary_run_test_engine_tb_top;
    localparam logic [15:0] T16A = 16'hD008;
    localparam logic [15:0] T16B = 16'hB400;
    localparam logic [7:0]  T8A  = 8'hB8;
    localparam logic [7:0]  T8B  = 8'h8E;
    localparam logic [2:0]  OPCS [13] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4,
        3'h5, 3'h6, 3'h7, 3'h1, 3'h7, 3'h2, 3'h1, 3'h1};
    localparam logic [7:0]  MASKS [13] = '{8'h00, 8'h00, 8'hF0, 8'hFF,
        8'h00, 8'h00, 8'hFF, 8'h3C, 8'h00, 8'h00, 8'h81, 8'h00, 8'h00};
    localparam logic [39:0] SEEDS [4] = '{40'h80_11_22_FE_5A,
        40'h40_FE_33_44_55, 40'h80_00_00_00_00, 40'hC0_11_22_FE_5A};
    localparam int          SEL [13] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 1,
        2, 3};

    logic        clk_sys;
    logic        rstn;
    logic        tck;
    logic        tdi;
    logic        run_idle;
    logic        cap_dr;
    logic        shift_dr;
    logic        upd_dr;
    logic        ctl_test;
    logic        ctl_norm;
    logic        tdo_oe;
    logic        run_op;
    logic        chain_sel;
    logic [7:0]  a_pins_in;
    logic [7:0]  b_pins_in;
    logic [7:0]  a_pins_out;
    logic [7:0]  b_pins_out;
    logic        a_pins_oe;
    logic        b_pins_oe;
    logic [7:0]  core_a_in;
    logic [7:0]  core_b_in;
    logic        tdo;
    logic        test_mode;
    logic [10:0] run_test_control;
    logic        sys_run_active;
    logic        sys_a_to_b;
    logic [39:0] dout;
    logic [39:0] sr_m;
    logic [39:0] sh_m;
    logic [2:0]  cur_opc;
    logic [7:0]  cur_mask;
    int          error_cnt = 0;
    int          samples_checked = 0;
    wire  [39:0] pins_seen = {4'h0, tdo_oe, a_pins_out, b_pins_out,
                              core_a_in, core_b_in, a_pins_oe, b_pins_oe,
                              test_mode};

    brt_engine #(
        .TAPS16_AB (T16A),
        .TAPS16_BA (T16B),
        .TAPS8_AB  (T8A),
        .TAPS8_BA  (T8B)
    ) u_dut (
        .clk_sys(clk_sys), .rstn(rstn), .tck(tck), .tdi(tdi),
        .tap_run_idle(run_idle), .tap_capture_dr(cap_dr),
        .tap_shift_dr(shift_dr), .tap_update_dr(upd_dr),
        .control_scan_normal(ctl_norm), .control_scan_test(ctl_test),
        .run_boundary_test_op(run_op), .chain_select(chain_sel),
        .a_pins_in(a_pins_in), .b_pins_in(b_pins_in),
        .a_pins_out(a_pins_out), .b_pins_out(b_pins_out),
        .a_pins_oe(a_pins_oe), .b_pins_oe(b_pins_oe),
        .core_a_in(core_a_in), .core_b_in(core_b_in), .tdo(tdo),
        .tdo_oe(tdo_oe), .test_mode(test_mode),
        .run_test_control(run_test_control),
        .sys_run_active(sys_run_active), .sys_a_to_b(sys_a_to_b)
    );

    brt_tap_model u_tap (
        .tck(tck), .tdi(tdi), .tap_run_idle(run_idle),
        .tap_capture_dr(cap_dr), .tap_shift_dr(shift_dr),
        .tap_update_dr(upd_dr), .control_scan_test(ctl_test),
        .control_scan_normal(ctl_norm),
        .run_boundary_test_op(run_op), .chain_select(chain_sel),
        .tdo(tdo)
    );

    // ----------------------------------------------------------------
    // Reference model and checks
    // ----------------------------------------------------------------
    function automatic logic [15:0] nx16(input logic [15:0] s,
                                         input logic [15:0] t);
        return {s[14:0], ^(s & t)};
    endfunction : nx16

    function automatic logic [7:0] nx8(input logic [7:0] s,
                                       input logic [7:0] t);
        return {s[6:0], ^(s & t)};
    endfunction : nx8

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    task automatic cmp_pins();
        logic [39:0] exp;
        exp = {4'h0, 1'b0, sh_m[31:24], sh_m[15:8], sh_m[7:0], sh_m[23:16],
               ~sh_m[39], ~sh_m[38], 1'b1};
        check(pins_seen, exp);
    endtask : cmp_pins

    // One rising test-clock edge of the chain, as the operation defines it.
    task automatic model_step();
        logic [7:0] pin;
        logic [7:0] mp;
        logic [7:0] in_l;
        logic [7:0] out_l;
        logic [8:0] cnt;
        logic [15:0] w;
        logic        d;
        int          i0;
        int          o0;
        int          p0;
        d = sr_m[39];
        if (sr_m[39] == sr_m[38]) return;
        i0 = d ? 0 : 16;
        o0 = d ? 8 : 24;
        p0 = d ? 24 : 8;
        pin = d ? a_pins_in : b_pins_in;
        mp = pin & ~cur_mask;
        in_l = sr_m[i0+:8];
        out_l = sr_m[o0+:8];
        if (cur_opc[1:0] == 2'h3) begin
            in_l = nx8(in_l, d ? T8A : T8B) ^ mp;
            cnt = {1'b0, out_l} + 9'h001;
            out_l = cur_opc[2] ? cnt[7:0] : nx8(out_l, d ? T8A : T8B);
            if (cur_opc[2]) sr_m[p0+:8] = sr_m[p0+:8] + {7'h00, cnt[8]};
        end else if (cur_opc[1:0] == 2'h0) begin
            in_l = pin;
            out_l = ~out_l;
        end else begin
            w = nx16({out_l, in_l}, d ? T16A : T16B);
            {out_l, in_l} = w ^ {8'h00, cur_opc[1] ? mp : 8'h00};
        end
        sr_m[i0+:8] = in_l;
        sr_m[o0+:8] = out_l;
        sh_m[i0+:8] = in_l;
        if (cur_opc[1:0] != 2'h2) sh_m[o0+:8] = out_l;
    endtask : model_step

    // ----------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ----------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // The whole sequence needs about 110 us of test clock.
    initial begin
        #400000;
        error_cnt++;
        end_sim();
    end

    initial begin
        rstn = 1'b0;
        a_pins_in = 8'hA7;
        b_pins_in = 8'hC3;
        u_tap.pulse();
        u_tap.pulse();
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        rstn = 1'b1;
        check({29'h0, run_test_control}, 40'h0);
        u_tap.scan(1'b1, 11, 40'h529, dout);
        check({29'h0, run_test_control}, 40'h529);
        u_tap.use_normal = 1'b1;
        u_tap.scan(1'b1, 11, 40'h2A6, dout);
        u_tap.use_normal = 1'b0;
        check({29'h0, dout[10:0]}, 40'h529);
        check({29'h0, run_test_control}, 40'h2A6);
        for (int k = 0; k < 13; k++) begin
            cur_opc = OPCS[k];
            cur_mask = MASKS[k];
            sr_m = SEEDS[SEL[k]];
            sh_m = sr_m;
            u_tap.scan(1'b0, 40, sr_m, dout);
            u_tap.scan(1'b1, 11, {29'h0, cur_mask, cur_opc}, dout);
            u_tap.run(2, 1'b0);
            cmp_pins();
            for (int s = 0; s < 4; s++) begin
                u_tap.run(1, 1'b1);
                model_step();
                cmp_pins();
            end
            check({38'h0, sys_run_active, sys_a_to_b},
                  {38'h0, sr_m[39] ^ sr_m[38],
                   sr_m[39] & ~sr_m[38]});
            u_tap.scan(1'b0, 40, sr_m, dout);
            check(dout, sr_m);
        end
        u_tap.bypass_scan(1'b1, dout[1:0]);
        check({37'h0, tdo_oe, dout[1:0]}, 40'h6);
        end_sim();
    end
endmodule : boundary_run_test_engine_tb_top
